// [design/cbs_pkg.sv]
package cbs_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int WDATA_W = 32;
  localparam int CNT_W = 8;
  localparam int STEP_W = 3;

  // address offsets from the head of the instruction and from operands
  localparam logic [ADDR_W-1:0] OFS_W2 = 24'h000002;
  localparam logic [ADDR_W-1:0] OFS_W3 = 24'h000004;
  localparam logic [ADDR_W-1:0] OFS_W4 = 24'h000006;
  localparam logic [ADDR_W-1:0] OFS_W5 = 24'h000008;
  localparam logic [ADDR_W-1:0] OFS_HALF = 24'h000002;
  localparam logic [ADDR_W-1:0] OFS_LONG = 24'h000004;
  localparam logic [ADDR_W-1:0] OFS_BYTE = 24'h000001;

  // internal-operation state counts
  localparam logic [CNT_W-1:0] DIV_B_STATES = 8'h0b;
  localparam logic [CNT_W-1:0] DIV_W_STATES = 8'h13;
  localparam logic [CNT_W-1:0] ONE_STATE = 8'h01;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  localparam logic [STEP_W-1:0] STEP_ONE = 3'h1;
  localparam logic [STEP_W-1:0] STEP_SKIP = 3'h2;
  localparam logic [STEP_W-1:0] LOOP_HEAD = 3'h3;
  localparam logic [STEP_W-1:0] LOOP_TAIL = 3'h4;

  localparam logic WIDE = 1'b1;
  localparam logic NARROW = 1'b0;
  localparam logic LOCKED = 1'b1;
  localparam logic OPEN = 1'b0;

  typedef enum logic [4:0] {
    OP_UDIV_B = 5'h00, OP_UDIV_W = 5'h01, OP_SDIV_B = 5'h02, OP_SDIV_W = 5'h03,
    OP_BIT_RMW = 5'h04, OP_BIT_TEST = 5'h05, OP_REL_CALL8 = 5'h06,
    OP_REL_CALL16 = 5'h07, OP_JUMP_ABS = 5'h08, OP_JUMP_IND = 5'h09,
    OP_CALL_IND = 5'h0a, OP_POP_MULTI = 5'h0b, OP_BLOCK_MOVE = 5'h0c,
    OP_CMP_REG = 5'h0d, OP_COND_LOAD = 5'h0e, OP_LONG_LD_D32 = 5'h0f,
    OP_BYTE_LD_INC = 5'h10, OP_BYTE_ST_DEC = 5'h11, OP_LONG_RD = 5'h12,
    OP_LONG_WR = 5'h13, OP_ACC_CLEAR = 5'h14, OP_ACC_LOAD = 5'h15,
    OP_MUL_ACC = 5'h16
  } cbs_op_t;

  typedef enum logic [1:0] {K_INT = 2'h0, K_RD = 2'h1, K_WR = 2'h2} cbs_kind_t;

  typedef enum logic [3:0] {
    A_W2 = 4'h0, A_W3 = 4'h1, A_W4 = 4'h2, A_W5 = 4'h3, A_NEXT = 4'h4,
    A_EA = 4'h5, A_EA2 = 4'h6, A_TGT = 4'h7, A_PUSH_HI = 4'h8,
    A_PUSH_LO = 4'h9, A_POP_HI = 4'ha, A_POP_LO = 4'hb, A_VEC = 4'hc,
    A_VEC2 = 4'hd, A_SRC = 4'he, A_DST = 4'hf
  } cbs_addr_t;

  typedef enum logic [1:0] {N_ONE = 2'h0, N_DIV_B = 2'h1, N_DIV_W = 2'h2} cbs_nsel_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_ISSUE = 5'h02, ST_BUS = 5'h04, ST_INT = 5'h08, ST_DONE = 5'h10
  } cbs_state_t;

  typedef struct packed {
    cbs_kind_t kind;
    logic wide;
    logic lock;
    cbs_addr_t asel;
    cbs_nsel_t nsel;
    logic skip;
    logic rpt;
    logic last;
  } cbs_step_t;

  typedef struct packed {
    cbs_op_t op;
    logic [ADDR_W-1:0] pc;
    logic [ADDR_W-1:0] next_pc;
    logic [ADDR_W-1:0] ea;
    logic [ADDR_W-1:0] target;
    logic [7:0] vec;
    logic [ADDR_W-1:0] sp;
    logic [ADDR_W-1:0] general_register_five;
    logic [ADDR_W-1:0] general_register_six;
    logic [CNT_W-1:0] count;
    logic [WDATA_W-1:0] wdata;
  } cbs_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic wide;
    logic lock;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cbs_bus_t;

  // number of steps in each sequence; zero marks an unsupported operation
  function automatic logic [STEP_W-1:0] seq_len(input cbs_op_t op);
    case (op)
      OP_CMP_REG: seq_len = 3'h1;
      OP_UDIV_B, OP_UDIV_W: seq_len = 3'h2;
      OP_SDIV_B, OP_SDIV_W, OP_BIT_TEST, OP_JUMP_ABS, OP_COND_LOAD,
      OP_BYTE_LD_INC, OP_BYTE_ST_DEC: seq_len = 3'h3;
      OP_BIT_RMW, OP_REL_CALL8, OP_LONG_RD, OP_LONG_WR: seq_len = 3'h4;
      OP_REL_CALL16, OP_JUMP_IND, OP_POP_MULTI: seq_len = 3'h5;
      OP_CALL_IND, OP_BLOCK_MOVE: seq_len = 3'h6;
      OP_LONG_LD_D32: seq_len = 3'h7;
      default: seq_len = 3'h0;
    endcase
  endfunction

endpackage

// [design/cbs_addr_gen.sv]
`timescale 1ns/1ps
`default_nettype none
module cbs_addr_gen import cbs_pkg::*; (
  // step selection
  input wire cbs_addr_t asel_i,
  input wire logic wide_i,
  // captured request and running pointers
  input wire cbs_req_t req_i,
  input wire logic [ADDR_W-1:0] tgt_i,
  input wire logic [ADDR_W-1:0] sp_i,
  input wire logic [ADDR_W-1:0] src_i,
  input wire logic [ADDR_W-1:0] dst_i,
  input wire logic [7:0] move_i,
  // bus address and write data
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] wdata_o
);

  always_comb begin
    addr_o = req_i.next_pc;
    wdata_o = '0;
    case (asel_i)
      A_W2: addr_o = req_i.pc + OFS_W2;
      A_W3: addr_o = req_i.pc + OFS_W3;
      A_W4: addr_o = req_i.pc + OFS_W4;
      A_W5: addr_o = req_i.pc + OFS_W5;
      A_NEXT: addr_o = req_i.next_pc;
      A_EA: begin
        addr_o = req_i.ea;
        wdata_o = wide_i ? req_i.wdata[31:16] : {8'h00, req_i.wdata[7:0]};
      end
      A_EA2: begin
        addr_o = req_i.ea + OFS_HALF;
        wdata_o = req_i.wdata[15:0];
      end
      A_TGT: addr_o = tgt_i;
      // return address goes out high word at the lower address
      A_PUSH_HI: begin
        addr_o = req_i.sp - OFS_LONG;
        wdata_o = {8'h00, req_i.next_pc[23:16]};
      end
      A_PUSH_LO: begin
        addr_o = req_i.sp - OFS_HALF;
        wdata_o = req_i.next_pc[15:0];
      end
      A_POP_HI: addr_o = sp_i;
      A_POP_LO: addr_o = sp_i + OFS_HALF;
      A_VEC: addr_o = {16'h0000, req_i.vec};
      A_VEC2: addr_o = {16'h0000, req_i.vec} + OFS_HALF;
      A_SRC: addr_o = src_i;
      A_DST: begin
        addr_o = dst_i;
        wdata_o = {8'h00, move_i};
      end
      default: addr_o = req_i.next_pc;
    endcase
  end

endmodule
`default_nettype wire

// [design/cbs_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - unsigned byte divide: next fetch, then 11 internal states
// - unsigned word divide: next fetch, then 19 internal states
// - signed byte divide: word two, next fetch, then 11 internal states
// - signed word divide: word two, next fetch, then 19 internal states
// - bit modify: word two, locked byte read, locked next fetch, byte write
// - bit test or logic: byte read, then locked next fetch, no write
// - longword read: locked word at address, then word at address plus two
// - longword write: locked word at address, then word at address plus two
// - post-increment byte load: one internal state between next fetch and read
// - pre-decrement byte store: one internal state between next fetch and write
// - short relative call: next, target, locked high push, low push
// - long relative call: word two, one internal state, target, two pushes
// - absolute jump: word two, one internal state, target fetch
// - indirect jump: two locked vector reads, one internal state, target
// - indirect call: locked vector word, vector word, pushes, target fetch
// - multi pop: word two, locked next, internal, locked high, low, repeated
// - block move: word two, source, destination, repeat read-write, next fetch
// - accumulator operations are unsupported and make no bus cycle
// - register compare: only the next-instruction word fetch
// - long load d32: words two to five, three and four locked, next, two reads
// - condition code load: word two, next fetch, one word read
// - locked cycle keeps the bus held until the following cycle, or until idle with no request waiting
// - block move source from register five, destination from register six
// - move repeat count from count register; addresses step by one; zero skips
module cbs_sequencer import cbs_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // decoder request and status
  input wire logic req_valid_i,
  input wire cbs_req_t req_i,
  output logic req_ready_o,
  output logic done_o,
  output logic refused_o,
  output logic internal_o,
  // read data back to the datapath
  output logic rd_valid_o,
  output cbs_addr_t rd_sel_o,
  output logic [DATA_W-1:0] rd_data_o,
  // memory and peripheral bus
  output cbs_bus_t bus_o,
  input wire logic bus_ack_i,
  input wire logic [DATA_W-1:0] bus_rdata_i
);

  function automatic cbs_step_t mk(input cbs_kind_t k, input logic w, input logic l,
                                   input cbs_addr_t a, input cbs_nsel_t n);
    mk = '0;
    mk.kind = k;
    mk.wide = w;
    mk.lock = l;
    mk.asel = a;
    mk.nsel = n;
  endfunction

  function automatic cbs_step_t rw(input cbs_addr_t a, input logic l);
    rw = mk(K_RD, WIDE, l, a, N_ONE);
  endfunction

  function automatic cbs_step_t rb(input cbs_addr_t a, input logic l);
    rb = mk(K_RD, NARROW, l, a, N_ONE);
  endfunction

  function automatic cbs_step_t ww(input cbs_addr_t a, input logic l);
    ww = mk(K_WR, WIDE, l, a, N_ONE);
  endfunction

  function automatic cbs_step_t wb(input cbs_addr_t a, input logic l);
    wb = mk(K_WR, NARROW, l, a, N_ONE);
  endfunction

  function automatic cbs_step_t iop(input cbs_nsel_t n);
    iop = mk(K_INT, NARROW, OPEN, A_NEXT, n);
  endfunction

  // one table for all sequences, indexed by operation and step number
  function automatic cbs_step_t step_of(input cbs_op_t op, input logic [STEP_W-1:0] idx);
    cbs_step_t s;
    s = iop(N_ONE);
    case ({op, idx})
      {OP_UDIV_B, 3'h0}: s = rw(A_NEXT, OPEN);
      {OP_UDIV_B, 3'h1}: s = iop(N_DIV_B);
      {OP_UDIV_W, 3'h0}: s = rw(A_NEXT, OPEN);
      {OP_UDIV_W, 3'h1}: s = iop(N_DIV_W);
      {OP_SDIV_B, 3'h0}: s = rw(A_W2, OPEN);
      {OP_SDIV_B, 3'h1}: s = rw(A_NEXT, OPEN);
      {OP_SDIV_B, 3'h2}: s = iop(N_DIV_B);
      {OP_SDIV_W, 3'h0}: s = rw(A_W2, OPEN);
      {OP_SDIV_W, 3'h1}: s = rw(A_NEXT, OPEN);
      {OP_SDIV_W, 3'h2}: s = iop(N_DIV_W);
      {OP_BIT_RMW, 3'h0}: s = rw(A_W2, OPEN);
      {OP_BIT_RMW, 3'h1}: s = rb(A_EA, LOCKED);
      {OP_BIT_RMW, 3'h2}: s = rw(A_NEXT, LOCKED);
      {OP_BIT_RMW, 3'h3}: s = wb(A_EA, OPEN);
      {OP_BIT_TEST, 3'h0}: s = rw(A_W2, OPEN);
      {OP_BIT_TEST, 3'h1}: s = rb(A_EA, OPEN);
      {OP_BIT_TEST, 3'h2}: s = rw(A_NEXT, LOCKED);
      {OP_REL_CALL8, 3'h0}: s = rw(A_NEXT, OPEN);
      {OP_REL_CALL8, 3'h1}: s = rw(A_TGT, OPEN);
      {OP_REL_CALL8, 3'h2}: s = ww(A_PUSH_HI, LOCKED);
      {OP_REL_CALL8, 3'h3}: s = ww(A_PUSH_LO, OPEN);
      {OP_REL_CALL16, 3'h0}: s = rw(A_W2, OPEN);
      {OP_REL_CALL16, 3'h1}: s = iop(N_ONE);
      {OP_REL_CALL16, 3'h2}: s = rw(A_TGT, OPEN);
      {OP_REL_CALL16, 3'h3}: s = ww(A_PUSH_HI, LOCKED);
      {OP_REL_CALL16, 3'h4}: s = ww(A_PUSH_LO, OPEN);
      {OP_JUMP_ABS, 3'h0}: s = rw(A_W2, OPEN);
      {OP_JUMP_ABS, 3'h1}: s = iop(N_ONE);
      {OP_JUMP_ABS, 3'h2}: s = rw(A_TGT, OPEN);
      {OP_JUMP_IND, 3'h0}: s = rw(A_NEXT, OPEN);
      {OP_JUMP_IND, 3'h1}: s = rw(A_VEC, LOCKED);
      {OP_JUMP_IND, 3'h2}: s = rw(A_VEC2, LOCKED);
      {OP_JUMP_IND, 3'h3}: s = iop(N_ONE);
      {OP_JUMP_IND, 3'h4}: s = rw(A_TGT, OPEN);
      {OP_CALL_IND, 3'h0}: s = rw(A_NEXT, OPEN);
      {OP_CALL_IND, 3'h1}: s = rw(A_VEC, LOCKED);
      {OP_CALL_IND, 3'h2}: s = rw(A_VEC2, OPEN);
      {OP_CALL_IND, 3'h3}: s = ww(A_PUSH_HI, LOCKED);
      {OP_CALL_IND, 3'h4}: s = ww(A_PUSH_LO, OPEN);
      {OP_CALL_IND, 3'h5}: s = rw(A_TGT, OPEN);
      {OP_POP_MULTI, 3'h0}: s = rw(A_W2, OPEN);
      {OP_POP_MULTI, 3'h1}: s = rw(A_NEXT, LOCKED);
      {OP_POP_MULTI, 3'h2}: s = iop(N_ONE);
      {OP_POP_MULTI, 3'h3}: s = rw(A_POP_HI, LOCKED);
      {OP_POP_MULTI, 3'h4}: s = rw(A_POP_LO, OPEN);
      {OP_BLOCK_MOVE, 3'h0}: s = rw(A_W2, OPEN);
      {OP_BLOCK_MOVE, 3'h1}: s = rb(A_SRC, OPEN);
      {OP_BLOCK_MOVE, 3'h2}: s = rb(A_DST, OPEN);
      {OP_BLOCK_MOVE, 3'h3}: s = rb(A_SRC, OPEN);
      {OP_BLOCK_MOVE, 3'h4}: s = wb(A_DST, OPEN);
      {OP_BLOCK_MOVE, 3'h5}: s = rw(A_NEXT, OPEN);
      {OP_CMP_REG, 3'h0}: s = rw(A_NEXT, OPEN);
      {OP_COND_LOAD, 3'h0}: s = rw(A_W2, OPEN);
      {OP_COND_LOAD, 3'h1}: s = rw(A_NEXT, OPEN);
      {OP_COND_LOAD, 3'h2}: s = rw(A_EA, OPEN);
      {OP_LONG_LD_D32, 3'h0}: s = rw(A_W2, OPEN);
      {OP_LONG_LD_D32, 3'h1}: s = rw(A_W3, LOCKED);
      {OP_LONG_LD_D32, 3'h2}: s = rw(A_W4, LOCKED);
      {OP_LONG_LD_D32, 3'h3}: s = rw(A_W5, OPEN);
      {OP_LONG_LD_D32, 3'h4}: s = rw(A_NEXT, OPEN);
      {OP_LONG_LD_D32, 3'h5}: s = rw(A_EA, LOCKED);
      {OP_LONG_LD_D32, 3'h6}: s = rw(A_EA2, OPEN);
      {OP_BYTE_LD_INC, 3'h0}: s = rw(A_NEXT, OPEN);
      {OP_BYTE_LD_INC, 3'h1}: s = iop(N_ONE);
      {OP_BYTE_LD_INC, 3'h2}: s = rb(A_EA, OPEN);
      {OP_BYTE_ST_DEC, 3'h0}: s = rw(A_NEXT, OPEN);
      {OP_BYTE_ST_DEC, 3'h1}: s = iop(N_ONE);
      {OP_BYTE_ST_DEC, 3'h2}: s = wb(A_EA, OPEN);
      {OP_LONG_RD, 3'h0}: s = rw(A_W2, OPEN);
      {OP_LONG_RD, 3'h1}: s = rw(A_NEXT, LOCKED);
      {OP_LONG_RD, 3'h2}: s = rw(A_EA, LOCKED);
      {OP_LONG_RD, 3'h3}: s = rw(A_EA2, OPEN);
      {OP_LONG_WR, 3'h0}: s = rw(A_W2, OPEN);
      {OP_LONG_WR, 3'h1}: s = rw(A_NEXT, LOCKED);
      {OP_LONG_WR, 3'h2}: s = ww(A_EA, LOCKED);
      {OP_LONG_WR, 3'h3}: s = ww(A_EA2, OPEN);
      default: s = iop(N_ONE);
    endcase
    s.skip = (op == OP_BLOCK_MOVE) && (idx == LOOP_HEAD);
    s.rpt = ((op == OP_BLOCK_MOVE) || (op == OP_POP_MULTI)) && (idx == LOOP_TAIL);
    s.last = (idx == seq_len(op) - STEP_ONE);
    return s;
  endfunction

  function automatic logic [CNT_W-1:0] int_states(input cbs_nsel_t n);
    case (n)
      N_DIV_B: int_states = DIV_B_STATES;
      N_DIV_W: int_states = DIV_W_STATES;
      default: int_states = ONE_STATE;
    endcase
  endfunction

  cbs_state_t state_q, state_d;
  logic [STEP_W-1:0] step_q, step_d;
  cbs_req_t req_q, req_d;
  logic [ADDR_W-1:0] tgt_q, tgt_d;
  logic [ADDR_W-1:0] sp_q, sp_d;
  logic [ADDR_W-1:0] src_q, src_d;
  logic [ADDR_W-1:0] dst_q, dst_d;
  logic [CNT_W-1:0] loop_q, loop_d;
  logic [CNT_W-1:0] icnt_q, icnt_d;
  logic [7:0] move_q, move_d;
  cbs_bus_t bus_q, bus_d;
  logic ready_q, ready_d;
  logic done_q, done_d;
  logic refused_q, refused_d;
  logic internal_q, internal_d;
  logic rd_valid_q, rd_valid_d;
  cbs_addr_t rd_sel_q, rd_sel_d;
  logic [DATA_W-1:0] rd_data_q, rd_data_d;
  cbs_step_t cur;
  logic adv;
  logic [ADDR_W-1:0] step_addr;
  logic [DATA_W-1:0] step_wdata;

  assign cur = step_of(req_q.op, step_q);

  cbs_addr_gen u_agen (
    .asel_i(cur.asel),
    .wide_i(cur.wide),
    .req_i(req_q),
    .tgt_i(tgt_q),
    .sp_i(sp_q),
    .src_i(src_q),
    .dst_i(dst_q),
    .move_i(move_q),
    .addr_o(step_addr),
    .wdata_o(step_wdata)
  );

  always_comb begin
    state_d = state_q;
    step_d = step_q;
    req_d = req_q;
    tgt_d = tgt_q;
    sp_d = sp_q;
    src_d = src_q;
    dst_d = dst_q;
    loop_d = loop_q;
    icnt_d = icnt_q;
    move_d = move_q;
    bus_d = bus_q;
    refused_d = 1'b0;
    internal_d = internal_q;
    rd_valid_d = 1'b0;
    rd_sel_d = rd_sel_q;
    rd_data_d = rd_data_q;
    adv = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (req_valid_i) begin
          req_d = req_i;
          tgt_d = req_i.target;
          sp_d = req_i.sp;
          src_d = req_i.general_register_five;
          dst_d = req_i.general_register_six;
          loop_d = req_i.count;
          step_d = '0;
          if (seq_len(req_i.op) == '0) begin
            refused_d = 1'b1;
            state_d = ST_DONE;
          end else begin
            state_d = ST_ISSUE;
          end
        end else begin
          // nothing follows, so a trailing hold is let go
          bus_d.lock = 1'b0;
        end
      end
      ST_ISSUE: begin
        if (cur.skip && (loop_q == '0)) begin
          step_d = step_q + STEP_SKIP;
        end else if (cur.kind == K_INT) begin
          icnt_d = int_states(cur.nsel);
          internal_d = 1'b1;
          state_d = ST_INT;
        end else begin
          // lock replaces the previous one only as this cycle starts
          bus_d.valid = 1'b1;
          bus_d.write = (cur.kind == K_WR);
          bus_d.wide = cur.wide;
          bus_d.lock = cur.lock;
          bus_d.addr = step_addr;
          bus_d.wdata = step_wdata;
          state_d = ST_BUS;
        end
      end
      ST_BUS: begin
        if (bus_ack_i) begin
          bus_d.valid = 1'b0;
          if (!bus_q.write) begin
            rd_valid_d = 1'b1;
            rd_sel_d = cur.asel;
            rd_data_d = bus_rdata_i;
            if (cur.asel == A_VEC) begin
              tgt_d[23:16] = bus_rdata_i[7:0];
            end
            if (cur.asel == A_VEC2) begin
              tgt_d[15:0] = bus_rdata_i;
            end
            if (cur.asel == A_SRC) begin
              move_d = bus_rdata_i[7:0];
            end
          end
          adv = 1'b1;
        end
      end
      ST_INT: begin
        if (icnt_q == CNT_ONE) begin
          internal_d = 1'b0;
          adv = 1'b1;
        end else begin
          icnt_d = icnt_q - CNT_ONE;
        end
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (adv) begin
      if (cur.rpt) begin
        loop_d = loop_q - CNT_ONE;
        if (req_q.op == OP_POP_MULTI) begin
          sp_d = sp_q + OFS_LONG;
        end else begin
          src_d = src_q + OFS_BYTE;
          dst_d = dst_q + OFS_BYTE;
        end
      end
      if (cur.rpt && (loop_q > CNT_ONE)) begin
        step_d = step_q - STEP_ONE;
        state_d = ST_ISSUE;
      end else if (cur.last) begin
        state_d = ST_DONE;
      end else begin
        step_d = step_q + STEP_ONE;
        state_d = ST_ISSUE;
      end
    end
    done_d = (state_d == ST_DONE);
    ready_d = (state_d == ST_IDLE);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
      step_q <= '0;
      req_q <= '0;
      tgt_q <= '0;
      sp_q <= '0;
      src_q <= '0;
      dst_q <= '0;
      loop_q <= '0;
      icnt_q <= '0;
      move_q <= '0;
      bus_q <= '0;
      ready_q <= 1'b1;
      done_q <= 1'b0;
      refused_q <= 1'b0;
      internal_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_sel_q <= A_W2;
      rd_data_q <= '0;
    end else begin
      state_q <= state_d;
      step_q <= step_d;
      req_q <= req_d;
      tgt_q <= tgt_d;
      sp_q <= sp_d;
      src_q <= src_d;
      dst_q <= dst_d;
      loop_q <= loop_d;
      icnt_q <= icnt_d;
      move_q <= move_d;
      bus_q <= bus_d;
      ready_q <= ready_d;
      done_q <= done_d;
      refused_q <= refused_d;
      internal_q <= internal_d;
      rd_valid_q <= rd_valid_d;
      rd_sel_q <= rd_sel_d;
      rd_data_q <= rd_data_d;
    end
  end

  assign req_ready_o = ready_q;
  assign done_o = done_q;
  assign refused_o = refused_q;
  assign internal_o = internal_q;
  assign rd_valid_o = rd_valid_q;
  assign rd_sel_o = rd_sel_q;
  assign rd_data_o = rd_data_q;
  assign bus_o = bus_q;

endmodule
`default_nettype wire

// [sim/cbs_sequencer_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module cbs_sequencer_assertions import cbs_pkg::*; (
  // clock, reset and decoder side
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic req_valid_i,
  input wire cbs_req_t req_i,
  input wire logic req_ready_o,
  input wire logic done_o,
  input wire logic refused_o,
  input wire logic internal_o,
  input wire logic rd_valid_o,
  input wire cbs_addr_t rd_sel_o,
  input wire logic [DATA_W-1:0] rd_data_o,
  // bus side
  input wire cbs_bus_t bus_o,
  input wire logic bus_ack_i,
  input wire logic [DATA_W-1:0] bus_rdata_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [7:0] run_q;
  logic [7:0] run_d;
  wire logic take = req_valid_i && req_ready_o;
  wire logic fin = bus_o.valid && bus_ack_i;
  // length of the current run of internal states
  always_comb run_d = internal_o ? run_q + 8'h01 : 8'h00;
  always_ff @(posedge clk_i) run_q <= sys_rst_i ? 8'h00 : run_d;
  property p_hold; bus_o.valid && !bus_ack_i |=> bus_o.valid && $stable(bus_o); endproperty
  a_hold: assert property (p_hold) else $error("bus cycle moved before ack");
  property p_gap; fin |=> !bus_o.valid; endproperty
  a_gap: assert property (p_gap) else $error("no idle cycle after ack");
  property p_rd; fin && bus_o.wide && !bus_o.write |=> rd_valid_o && rd_data_o == $past(bus_rdata_i);
  endproperty
  a_rd: assert property (p_rd) else $error("read data not returned");
  property p_ref; take && req_i.op inside {OP_ACC_CLEAR, OP_ACC_LOAD, OP_MUL_ACC}
    |=> done_o && refused_o && !bus_o.valid; endproperty
  a_ref: assert property (p_ref) else $error("accumulator op not refused");
  property p_cmp; take && req_i.op == OP_CMP_REG
    |-> ##2 bus_o.valid && bus_o.addr == $past(req_i.next_pc, 2); endproperty
  a_cmp: assert property (p_cmp) else $error("compare fetch wrong");
  property p_int; $fell(internal_o) |-> run_q inside {8'h01, 8'h0b, 8'h13}; endproperty
  a_int: assert property (p_int) else $error("internal run length wrong");
  property p_quiet; internal_o |-> !bus_o.valid; endproperty
  a_quiet: assert property (p_quiet) else $error("bus cycle in internal state");
  property p_lock; $fell(bus_o.valid) && $past(bus_o.lock) |-> bus_o.lock; endproperty
  a_lock: assert property (p_lock) else $error("lock dropped after cycle");
  property p_busy; take |=> !req_ready_o; endproperty
  a_busy: assert property (p_busy) else $error("ready during sequence");
  c_ref: cover property (take && req_i.op == OP_ACC_LOAD);
  c_int: cover property ($fell(internal_o) && run_q == 8'h13);
  c_lock: cover property (fin && bus_o.write && bus_o.lock);
endmodule
bind cbs_sequencer cbs_sequencer_assertions cbs_sequencer_assertions_inst (.clk_i, .sys_rst_i,
  .req_valid_i, .req_i, .req_ready_o, .done_o, .refused_o, .internal_o, .rd_valid_o,
  .rd_sel_o, .rd_data_o, .bus_o, .bus_ack_i, .bus_rdata_i);
`default_nettype wire

// [sim/cbs_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cbs_mem_model import cbs_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // bus from the sequencer
  input wire cbs_bus_t bus_i,
  input wire logic slow_i,
  output logic ack_o,
  output logic [DATA_W-1:0] rdata_o
);
  logic [1:0] wait_q;
  logic [1:0] wait_d;
  logic [DATA_W-1:0] last_q;
  logic [DATA_W-1:0] last_d;
  always_comb begin
    ack_o = bus_i.valid && (!slow_i || wait_q == 2'h2);
    wait_d = (bus_i.valid && !ack_o) ? wait_q + 2'h1 : 2'h0;
    // data flips outside an ack so a stale sample can never match
    rdata_o = ack_o ? bus_i.addr[15:0] ^ 16'h5a5a : ~last_q;
    last_d = rdata_o;
  end
  always_ff @(posedge clk_i) begin
    wait_q <= sys_rst_i ? 2'h0 : wait_d;
    last_q <= sys_rst_i ? 16'h0000 : last_d;
  end
endmodule
`default_nettype wire

// [sim/cbs_sequencer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t got %h exp %h", $time, (a), (b)); end end
module cbs_sequencer_tb import cbs_pkg::*;;
  localparam logic [ADDR_W-1:0] W2 = 24'h001002, NX = 24'h001004, EA = 24'h002000;
  localparam logic [ADDR_W-1:0] SP = 24'h00fff0, R5 = 24'h004000, R6 = 24'h005000;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, req_valid_i = 1'b0, slow = 1'b0, ack, refd;
  cbs_req_t req_i = '{op: OP_CMP_REG, pc: 24'h001000, next_pc: NX, ea: EA,
    target: 24'h003000, vec: 8'h40, sp: SP, general_register_five: R5,
    general_register_six: R6, count: 8'h00, wdata: 32'hcafe1234};
  logic req_ready_o, done_o, refused_o, internal_o, rd_valid_o;
  cbs_addr_t rd_sel_o;
  logic [DATA_W-1:0] rd_data_o, rdata;
  cbs_bus_t bus_o;
  logic [43:0] log_q[$];
  logic [43:0] x[$];
  int err_count = 0, tests_run = 0, icnt = 0;
  cbs_sequencer cbs_sequencer_inst (.clk_i, .sys_rst_i, .req_valid_i, .req_i, .req_ready_o,
    .done_o, .refused_o, .internal_o, .rd_valid_o, .rd_sel_o, .rd_data_o, .bus_o,
    .bus_ack_i(ack), .bus_rdata_i(rdata));
  cbs_mem_model cbs_mem_model_inst (.clk_i, .sys_rst_i, .bus_i(bus_o), .slow_i(slow),
    .ack_o(ack), .rdata_o(rdata));
  always #2.5 clk_i = ~clk_i;
  // log each completed cycle as {write, wide, lock, addr, data}
  always @(posedge clk_i) begin
    if (bus_o.valid && ack)
      log_q.push_back({bus_o.write, bus_o.wide, bus_o.lock, bus_o.addr, bus_o.write ?
        (bus_o.wide ? bus_o.wdata : {8'h00, bus_o.wdata[7:0]}) : 16'h0000});
    if (internal_o === 1'b1)
      icnt++;
  end
  function automatic logic [43:0] e(logic [2:0] f, logic [23:0] a, logic [15:0] d = 16'h0);
    return {f, a, d};
  endfunction
  task automatic close_out;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic run(input cbs_op_t op, input logic [7:0] n);
    int k;
    @(posedge clk_i);
    log_q = {};
    icnt = 0;
    req_i.op <= op;
    req_i.count <= n;
    req_valid_i <= 1'b1;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    // a refused op pulses done right after the take edge, so look before waiting
    for (k = 0; k < 400; k++) begin
      #1;
      if (done_o === 1'b1) break;
      @(posedge clk_i);
    end
    if (k == 400) begin err_count++; close_out(); end
    else refd = refused_o;
  endtask
  task automatic cmp_log;
    `CHK(log_q.size(), x.size())
    foreach (x[i]) if (i < log_q.size()) `CHK(log_q[i], x[i])
  endtask
  task automatic s_refuse;
    cbs_op_t ops[3] = '{OP_ACC_CLEAR, OP_ACC_LOAD, OP_MUL_ACC};
    foreach (ops[i]) begin
      run(ops[i], 8'h00);
      `CHK(refd, 1'b1)
      `CHK(log_q.size(), 0)
    end
  endtask
  task automatic s_div;
    cbs_op_t ops[4] = '{OP_UDIV_B, OP_UDIV_W, OP_SDIV_B, OP_SDIV_W};
    int n[4] = '{11, 19, 11, 19};
    foreach (ops[i]) begin
      run(ops[i], 8'h00);
      x = '{e(3'h2, NX)};
      if (i > 1) x.push_front(e(3'h2, W2));
      cmp_log();
      `CHK(icnt, n[i])
    end
  endtask
  task automatic s_bus;
    run(OP_CMP_REG, 8'h00);
    x = '{e(3'h2, NX)};
    cmp_log();
    `CHK(rd_sel_o, A_NEXT)
    `CHK(rd_data_o, 16'h4a5e)
    slow <= 1'b1;
    run(OP_BIT_RMW, 8'h00);
    x = '{e(3'h2, W2), e(3'h1, EA), e(3'h3, NX), e(3'h4, EA, 16'h0034)};
    cmp_log();
    run(OP_BIT_TEST, 8'h00);
    x = '{e(3'h2, W2), e(3'h0, EA), e(3'h3, NX)};
    cmp_log();
    slow <= 1'b0;
    run(OP_LONG_WR, 8'h00);
    x = '{e(3'h2, W2), e(3'h3, NX), e(3'h7, EA, 16'hcafe), e(3'h6, EA + 24'h2, 16'h1234)};
    cmp_log();
    run(OP_LONG_RD, 8'h00);
    x = '{e(3'h2, W2), e(3'h3, NX), e(3'h3, EA), e(3'h2, EA + 24'h2)};
    cmp_log();
    run(OP_CALL_IND, 8'h00);
    // target is built from the two vector words the memory model returns
    x = '{e(3'h2, NX), e(3'h3, 24'h40), e(3'h2, 24'h42), e(3'h7, SP - 24'h4, 16'h0000),
      e(3'h6, SP - 24'h2, 16'h1004), e(3'h2, 24'h1a5a18)};
    cmp_log();
  endtask
  task automatic s_move;
    run(OP_BLOCK_MOVE, 8'h00);
    x = '{e(3'h2, W2), e(3'h0, R5), e(3'h0, R6), e(3'h2, NX)};
    cmp_log();
    run(OP_BLOCK_MOVE, 8'h02);
    x = '{e(3'h2, W2), e(3'h0, R5), e(3'h0, R6)};
    for (int k = 0; k < 2; k++) begin
      x.push_back(e(3'h0, R5 + 24'(k)));
      x.push_back(e(3'h4, R6 + 24'(k), (R5[15:0] + 16'(k) ^ 16'h5a5a) & 16'h00ff));
    end
    x.push_back(e(3'h2, NX));
    cmp_log();
  endtask
  task automatic s_flow;
    logic [43:0] ph = e(3'h7, SP - 24'h4), pl = e(3'h6, SP - 24'h2, 16'h1004);
    logic [43:0] tg = e(3'h2, 24'h003000), nx = e(3'h2, NX), w2 = e(3'h2, W2);
    run(OP_REL_CALL8, 8'h00);
    x = '{nx, tg, ph, pl};
    cmp_log();
    run(OP_REL_CALL16, 8'h00);
    x = '{w2, tg, ph, pl};
    cmp_log();
    `CHK(icnt, 1)
    run(OP_JUMP_ABS, 8'h00);
    x = '{w2, tg};
    cmp_log();
    `CHK(icnt, 1)
    run(OP_JUMP_IND, 8'h00);
    x = '{nx, e(3'h3, 24'h40), e(3'h3, 24'h42), e(3'h2, 24'h1a5a18)};
    cmp_log();
    `CHK(icnt, 1)
    run(OP_COND_LOAD, 8'h00);
    x = '{w2, nx, e(3'h2, EA)};
    cmp_log();
    run(OP_LONG_LD_D32, 8'h00);
    x = '{w2, e(3'h3, 24'h1004), e(3'h3, 24'h1006), e(3'h2, 24'h1008), nx, e(3'h3, EA),
      e(3'h2, EA + 24'h2)};
    cmp_log();
    run(OP_BYTE_LD_INC, 8'h00);
    x = '{nx, e(3'h0, EA)};
    cmp_log();
    `CHK(icnt, 1)
    run(OP_BYTE_ST_DEC, 8'h00);
    x = '{nx, e(3'h4, EA, 16'h0034)};
    cmp_log();
    `CHK(icnt, 1)
    run(OP_POP_MULTI, 8'h02);
    x = '{w2, e(3'h3, NX), e(3'h3, SP), e(3'h2, SP + 24'h2), e(3'h3, SP + 24'h4),
      e(3'h2, SP + 24'h6)};
    cmp_log();
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    `CHK(req_ready_o, 1'b1)
    s_refuse();
    s_div();
    s_bus();
    s_move();
    s_flow();
    close_out();
  end
endmodule
`default_nettype wire
